/* core/converter_protection_sequencer_regs.vh */
// Constants and timing counts for the converter protection sequencer
// What this block does
// - Lock to external clock only within plus or minus twenty percent of oscillator.
// - After clock change, tracking settles in about 500 us; frequency may sag 25%.
// - Each channel cuts synchronous rectifier gate when its current crosses zero.
// - Sync output resistor sensed at start-up: absent enables detection, present disables.
// - Detection disabled: enter standby about 300 us after bias and enable valid.
// - Detection enabled: run a 2 to 3 ms short check on all switches.
// - No short found: enable breaker gate source; standby once gate exceeds 8.5 V.
// - Any shorted switch drives fault line low and latches shutdown, switching off.
// - External low on fault line opens the breaker and latches shutdown.
// - Fault line lows shorter than 2 us are ignored.
// - Latch clears only when enable below 1.25 V or bias below 8 V.
// - Breaker source stays on after start-up; no gate check when detection disabled.
// - Low-port overvoltage ignored in boost; high-port overvoltage active in both modes.
// - High-port overvoltage turns off all gates and discharges soft-start.
// - Low-port overvoltage outside boost turns off all gates, discharges soft-start.
// - Each overvoltage comparator result passes a 5 us glitch filter.
// - Hold soft-start pulldown during overvoltage; release once clear and below 0.23 V.
`ifndef CONVERTER_PROTECTION_SEQUENCER_REGS_VH
`define CONVERTER_PROTECTION_SEQUENCER_REGS_VH

`define CLK_MHZ            125
`define FAULT_FILTER_NS    2000
`define OVP_FILTER_NS      5000
`define STANDBY_DELAY_US   300
`define DETECT_TIME_US     2000
`define PLL_SETTLE_US      500
`define FAULT_FILTER_CYC   ((`FAULT_FILTER_NS * `CLK_MHZ) / 1000)
`define OVP_FILTER_CYC     ((`OVP_FILTER_NS * `CLK_MHZ) / 1000)
`define STANDBY_DELAY_CYC  (`STANDBY_DELAY_US * `CLK_MHZ)
`define DETECT_TIME_CYC    (`DETECT_TIME_US * `CLK_MHZ)
`define PLL_SETTLE_CYC     (`PLL_SETTLE_US * `CLK_MHZ)
`define CNT_W              20
`define FILT_W             10

`endif

/* core/converter_protection_sequencer.v */
// Start-up, fault latch and overvoltage sequencer of a two-channel converter
`timescale 1ns/1ps
`include "converter_protection_sequencer_regs.vh"

module converter_protection_sequencer #(
    parameter STANDBY_DELAY_CYC = `STANDBY_DELAY_CYC,
    parameter DETECT_TIME_CYC   = `DETECT_TIME_CYC,
    parameter PLL_SETTLE_CYC    = `PLL_SETTLE_CYC
) (
    input  wire       core_clk,               // System clock, 125 MHz
    input  wire       rst,                    // Async reset, active high
    input  wire       bias_good,              // Bias supply above 8.5 V
    input  wire       bias_low,               // Bias supply below 8 V
    input  wire       master_enable_sense,    // Master enable above 2.5 V
    input  wire       master_enable_low,      // Master enable below 1.25 V
    input  wire       sync_resistor_present,  // Resistor sensed on sync output pin
    input  wire       short_detected,         // Any switch found shorted during check
    input  wire       breaker_gate_good,      // Breaker gate-source above 8.5 V
    input  wire       fault_line_low_in,      // Fault line level, 1 = low
    input  wire       high_port_overvolt_sense, // High-port comparator above 1.185 V
    input  wire       low_port_overvolt_sense,  // Low-port comparator above 1.185 V
    input  wire       boost_mode,             // 1 = boost, 0 = buck
    input  wire       soft_start_low,         // Soft-start below 0.23 V
    input  wire       ch1_enable,             // Channel 1 enable
    input  wire       ch2_enable,             // Channel 2 enable
    input  wire       ch1_zero_cross,         // Channel 1 current crossed zero
    input  wire       ch2_zero_cross,         // Channel 2 current crossed zero
    input  wire       ext_clock_in_valid,     // External clock present
    input  wire       ext_clock_in_in_range,  // External clock within 20 percent
    input  wire       ext_clock_in_changed,   // External clock frequency changed
    output reg        fault_line_low_oe,      // Drive fault line low
    output reg        breaker_gate_drive,     // Breaker gate charge source on
    output reg        detect_active,          // Short check running
    output reg        standby,                // Standby or run
    output reg        ch1_switch_en,          // Channel 1 top and bottom gates allowed
    output reg        ch2_switch_en,          // Channel 2 top and bottom gates allowed
    output reg        ch1_rect_en,            // Channel 1 synchronous rectifier allowed
    output reg        ch2_rect_en,            // Channel 2 synchronous rectifier allowed
    output reg        soft_start_pulldown,    // Soft-start discharge switch on
    output reg        ext_sync_locked,        // Switching follows external clock
    output reg        pll_settling,           // Tracking settling after clock change
    output reg  [2:0] seq_state               // Sequencer state
);

    // DELAY is the timed wait used when the check is skipped
    localparam [2:0] ST_OFF     = 3'h0;
    localparam [2:0] ST_DETECT  = 3'h1;
    localparam [2:0] ST_CHARGE  = 3'h2;
    localparam [2:0] ST_STANDBY = 3'h3;
    localparam [2:0] ST_RUN     = 3'h4;
    localparam [2:0] ST_FAULT   = 3'h5;
    localparam [2:0] ST_DELAY   = 3'h6;

    // Counts cut to counter width on purpose
    localparam integer       FAULT_I   = `FAULT_FILTER_CYC;
    localparam integer       OVP_I     = `OVP_FILTER_CYC;
    localparam [`CNT_W-1:0]  STANDBY_N = STANDBY_DELAY_CYC[`CNT_W-1:0];
    localparam [`CNT_W-1:0]  DETECT_N  = DETECT_TIME_CYC[`CNT_W-1:0];
    localparam [`CNT_W-1:0]  SETTLE_N  = PLL_SETTLE_CYC[`CNT_W-1:0];
    localparam [`FILT_W-1:0] FAULT_N   = FAULT_I[`FILT_W-1:0];
    localparam [`FILT_W-1:0] OVP_N     = OVP_I[`FILT_W-1:0];

    // Two-stage synchronisers; first stage read only by the second
    localparam NSYNC = 17;
    reg [NSYNC-1:0] meta_q;
    reg [NSYNC-1:0] sync_q;
    wire [NSYNC-1:0] raw_in = {bias_good, bias_low, master_enable_sense, master_enable_low,
                               sync_resistor_present, short_detected, breaker_gate_good,
                               fault_line_low_in, high_port_overvolt_sense,
                               low_port_overvolt_sense, boost_mode, soft_start_low,
                               ch1_zero_cross, ch2_zero_cross, ext_clock_in_valid,
                               ext_clock_in_in_range, ext_clock_in_changed};

    always @(posedge core_clk or posedge rst) begin
        if (rst) begin
            meta_q <= {NSYNC{1'b0}};
            sync_q <= {NSYNC{1'b0}};
        end else begin
            meta_q <= raw_in;
            sync_q <= meta_q;
        end
    end

    // Supply and start-up flags
    wire s_bias_good  = sync_q[16];
    wire s_bias_low   = sync_q[15];
    wire s_en_good    = sync_q[14];
    wire s_en_low     = sync_q[13];
    wire s_sync_res   = sync_q[12];
    wire s_short      = sync_q[11];
    wire s_brk_good   = sync_q[10];

    // Fault line and overvoltage flags
    wire s_fault_in   = sync_q[9];
    wire s_ovp_hi     = sync_q[8];
    wire s_ovp_lo     = sync_q[7];
    wire s_boost      = sync_q[6];
    wire s_ss_low     = sync_q[5];

    // Channel and external clock flags
    wire s_zc1        = sync_q[4];
    wire s_zc2        = sync_q[3];
    wire s_ext_valid  = sync_q[2];
    wire s_ext_range  = sync_q[1];
    wire s_ext_change = sync_q[0];

    // Glitch filter step: count while raw level held, output follows after n cycles
    function [`FILT_W:0] filt_step;
        input             level;
        input [`FILT_W-1:0] cnt;
        input             out;
        input [`FILT_W-1:0] n;
        begin
            // Result is {output, count}
            if (level == out)
                filt_step = {out, {`FILT_W{1'b0}}};
            else if (cnt >= n - 1'b1)
                filt_step = {level, {`FILT_W{1'b0}}};
            else
                filt_step = {out, cnt + 1'b1};
        end
    endfunction

    // One filter per watched line
    reg [`FILT_W-1:0] fault_cnt_q;
    reg               fault_filt_q;
    reg [`FILT_W-1:0] ovh_cnt_q;
    reg               ovh_filt_q;
    reg [`FILT_W-1:0] ovl_cnt_q;
    reg               ovl_filt_q;
    // Count restarts when the input returns to the output level
    wire [`FILT_W:0]  fault_nx = filt_step(s_fault_in, fault_cnt_q, fault_filt_q, FAULT_N);
    wire [`FILT_W:0]  ovh_nx   = filt_step(s_ovp_hi, ovh_cnt_q, ovh_filt_q, OVP_N);
    wire [`FILT_W:0]  ovl_nx   = filt_step(s_ovp_lo, ovl_cnt_q, ovl_filt_q, OVP_N);

    always @(posedge core_clk or posedge rst) begin
        if (rst) begin
            fault_cnt_q  <= {`FILT_W{1'b0}};
            fault_filt_q <= 1'b0;
            ovh_cnt_q    <= {`FILT_W{1'b0}};
            ovh_filt_q   <= 1'b0;
            ovl_cnt_q    <= {`FILT_W{1'b0}};
            ovl_filt_q   <= 1'b0;
        end else begin
            {fault_filt_q, fault_cnt_q} <= fault_nx;
            {ovh_filt_q, ovh_cnt_q}     <= ovh_nx;
            {ovl_filt_q, ovl_cnt_q}     <= ovl_nx;
        end
    end

    // Own drive low must not be read back as an external shutdown request
    wire ext_fault = fault_filt_q & ~fault_line_low_oe;

    wire release_c = s_en_low | s_bias_low;
    wire supply_ok = s_bias_good & s_en_good;
    wire ov_active = ovh_filt_q | (ovl_filt_q & ~s_boost);

    // Main sequencer
    reg [2:0]        state_q;
    reg [2:0]        state_d;
    reg [`CNT_W-1:0] tmr_q;
    reg [`CNT_W-1:0] tmr_d;
    reg              detect_mode_q;
    reg              detect_mode_d;
    reg              shorted_q;
    reg              shorted_d;


    // Supply loss and external fault override the case below
    always @* begin
        state_d       = state_q;
        tmr_d         = tmr_q;
        detect_mode_d = detect_mode_q;
        shorted_d     = shorted_q;
        case (state_q)
            ST_OFF: begin
                tmr_d     = {`CNT_W{1'b0}};
                shorted_d = 1'b0;
                if (supply_ok) begin
                    detect_mode_d = ~s_sync_res;
                    state_d       = s_sync_res ? ST_DELAY : ST_DETECT;
                end
            end
            // Fixed wait, no gate check
            ST_DELAY: begin
                if (tmr_q >= STANDBY_N - 1'b1)
                    state_d = ST_STANDBY;
                else
                    tmr_d = tmr_q + 1'b1;
            end
            // A short seen once stays latched
            ST_DETECT: begin
                if (s_short)
                    shorted_d = 1'b1;
                if (s_short || shorted_q)
                    state_d = ST_FAULT;
                else if (tmr_q >= DETECT_N - 1'b1) begin
                    state_d = ST_CHARGE;
                    tmr_d   = {`CNT_W{1'b0}};
                end else
                    tmr_d = tmr_q + 1'b1;
            end
            // No timeout: an uncharged gate waits here
            ST_CHARGE: begin
                if (s_brk_good)
                    state_d = ST_STANDBY;
            end
            // Either enable starts delivery
            ST_STANDBY: begin
                if (ch1_enable | ch2_enable)
                    state_d = ST_RUN;
            end
            // Both enables low returns to standby
            ST_RUN: begin
                if (!(ch1_enable | ch2_enable))
                    state_d = ST_STANDBY;
            end
            // Latched until a release condition
            ST_FAULT: begin
                if (release_c)
                    state_d = ST_OFF;
            end
            default: state_d = ST_OFF;
        endcase
        // Supply loss restarts the sequence; fault only leaves via release
        if (state_q != ST_OFF && state_q != ST_FAULT && !supply_ok)
            state_d = ST_OFF;
        if (ext_fault && state_q != ST_OFF && state_q != ST_FAULT)
            state_d = ST_FAULT;
    end

    // Tracking settle timer and lock window
    // A held change restarts the count each cycle
    reg [`CNT_W-1:0] settle_q;
    wire settling = (settle_q != {`CNT_W{1'b0}});

    always @(posedge core_clk or posedge rst) begin
        if (rst) begin
            settle_q <= {`CNT_W{1'b0}};
        end else if (s_ext_change && s_ext_valid) begin
            settle_q <= SETTLE_N;
        end else if (settling) begin
            settle_q <= settle_q - 1'b1;
        end
    end

    // Gates only in run and never during filtered high-port or non-boost low-port overvoltage
    wire switching = (state_d == ST_RUN) && !ov_active;

    // Every top-level output comes from here
    always @(posedge core_clk or posedge rst) begin
        if (rst) begin
            state_q             <= ST_OFF;
            tmr_q               <= {`CNT_W{1'b0}};
            detect_mode_q       <= 1'b1;
            shorted_q           <= 1'b0;
            fault_line_low_oe   <= 1'b0;
            breaker_gate_drive  <= 1'b0;
            detect_active       <= 1'b0;
            standby             <= 1'b0;
            ch1_switch_en       <= 1'b0;
            ch2_switch_en       <= 1'b0;
            ch1_rect_en         <= 1'b0;
            ch2_rect_en         <= 1'b0;
            soft_start_pulldown <= 1'b1;
            ext_sync_locked     <= 1'b0;
            pll_settling        <= 1'b0;
            seq_state           <= ST_OFF;
        end else begin
            state_q       <= state_d;
            tmr_q         <= tmr_d;
            detect_mode_q <= detect_mode_d;
            shorted_q     <= shorted_d;

            // Outputs follow the next state, in step with seq_state
            seq_state     <= state_d;
            detect_active <= (state_d == ST_DETECT);
            standby       <= (state_d == ST_STANDBY) || (state_d == ST_RUN);
            // Only own short detection pulls the line; external lows are already there
            fault_line_low_oe  <= (state_d == ST_FAULT) && (shorted_d || fault_line_low_oe);
            // Source stays on after start-up, opens on fault or restart
            breaker_gate_drive <= (state_d == ST_CHARGE) || (state_d == ST_STANDBY) ||
                                  (state_d == ST_RUN) ||
                                  ((state_d == ST_DELAY) && !detect_mode_d);

            // Per-channel gate permission
            ch1_switch_en <= switching && ch1_enable;
            ch2_switch_en <= switching && ch2_enable;
            ch1_rect_en   <= switching && ch1_enable && !s_zc1;
            ch2_rect_en   <= switching && ch2_enable && !s_zc2;
            // Restart only after the capacitor has truly discharged
            if (ov_active || state_d != ST_RUN)
                soft_start_pulldown <= 1'b1;
            else if (soft_start_pulldown && s_ss_low)
                soft_start_pulldown <= 1'b0;

            // Window report only; the loop itself is outside
            ext_sync_locked <= s_ext_valid && s_ext_range;
            pll_settling    <= settling;
        end
    end

endmodule // converter_protection_sequencer

/* verification/converter_protection_sequencer_properties.sv */
// Port-level checks on the converter protection sequencer
`timescale 1ns/1ps
module converter_protection_sequencer_properties (
    input wire       core_clk,                 // Clock
    input wire       rst,                      // Reset
    input wire       bias_low,                 // Bias low
    input wire       master_enable_low,        // Enable low
    input wire       breaker_gate_good,        // Gate charged
    input wire       fault_line_low_in,        // Fault line
    input wire       high_port_overvolt_sense, // High OV
    input wire       low_port_overvolt_sense,  // Low OV
    input wire       ch1_enable,               // Enable 1
    input wire       ch1_zero_cross,           // Zero cross 1
    input wire       ext_clock_in_in_range,    // In window
    input wire       ext_clock_in_valid,       // Clock present
    input wire       ext_clock_in_changed,     // Changed
    input wire       fault_line_low_oe,        // Fault drive
    input wire       breaker_gate_drive,       // Breaker source
    input wire       detect_active,            // Checking
    input wire       ch1_switch_en,            // Gates 1
    input wire       ch2_switch_en,            // Gates 2
    input wire       ch1_rect_en,              // Rectifier 1
    input wire       soft_start_pulldown,      // Discharge
    input wire       ext_sync_locked,          // Locked
    input wire       pll_settling,             // Settling
    input wire [2:0] seq_state                 // State
);
    reg [9:0] flt_run_q;
    reg [9:0] hi_run_q;
    reg [9:0] lo_run_q;
    // Saturating run lengths so long holds never wrap
    always @(posedge core_clk or posedge rst) begin
        if (rst) begin
            flt_run_q <= 10'h0;
            hi_run_q  <= 10'h0;
            lo_run_q  <= 10'h0;
        end else begin
            flt_run_q <= fault_line_low_in ? flt_run_q + {9'h0, ~&flt_run_q} : 10'h0;
            hi_run_q  <= high_port_overvolt_sense ? hi_run_q + {9'h0, ~&hi_run_q} : 10'h0;
            lo_run_q  <= low_port_overvolt_sense ? lo_run_q + {9'h0, ~&lo_run_q} : 10'h0;
        end
    end
    default clocking @(posedge core_clk); endclocking
    default disable iff (rst);
    a_reset_to_off: assert property (
        $past(rst) |-> seq_state == 3'h0 && soft_start_pulldown && !breaker_gate_drive)
        else $error("sequencer not off after reset");
    a_detect_no_breaker: assert property (
        seq_state == 3'h1 && $past(seq_state) == 3'h1 |-> detect_active && !breaker_gate_drive)
        else $error("check state outputs wrong");
    a_charge_needs_gate: assert property (
        $past(seq_state) == 3'h2 && seq_state == 3'h3 |-> $past(breaker_gate_good, 3))
        else $error("standby before breaker gate charged");
    a_fault_all_off: assert property (
        seq_state == 3'h5 && $past(seq_state) == 3'h5
        |-> !breaker_gate_drive && !ch1_switch_en && !ch2_switch_en)
        else $error("switching or breaker on in fault");
    a_fault_drive_latched: assert property (
        fault_line_low_oe && $past(fault_line_low_oe) |-> seq_state == 3'h5)
        else $error("fault line driven outside fault");
    a_fault_release_cause: assert property (
        $past(seq_state) == 3'h5 && seq_state != 3'h5
        |-> seq_state == 3'h0 && ($past(master_enable_low, 3) || $past(bias_low, 3)))
        else $error("fault left without release");
    a_fault_glitch_filter: assert property (
        $past(seq_state) != 3'h5 && $past(seq_state) != 3'h1 && seq_state == 3'h5
        |-> $past(flt_run_q, 2) >= 10'd240)
        else $error("fault taken on a short low");
    a_ov_glitch_filter: assert property (
        $fell(ch1_switch_en) && seq_state == 3'h4 && ch1_enable
        |-> $past(hi_run_q, 2) >= 10'd600 || $past(lo_run_q, 2) >= 10'd600)
        else $error("gates cut without filtered overvoltage");
    a_zero_cross_cut: assert property (
        ch1_zero_cross [*4] |-> !ch1_rect_en)
        else $error("rectifier on after zero crossing");
    a_lock_window: assert property (
        (!ext_clock_in_in_range) [*4] |-> !ext_sync_locked)
        else $error("locked to clock outside window");
    a_clock_settle: assert property (
        (ext_clock_in_changed && ext_clock_in_valid) [*5] |-> pll_settling)
        else $error("no settling after clock change");
    c_standby: cover property (seq_state == 3'h3);
    c_short: cover property (fault_line_low_oe);
    c_run: cover property (seq_state == 3'h4 && ch1_switch_en);
endmodule // converter_protection_sequencer_properties

/* verification/converter_far_side.sv */
// Far-side model: breaker gate, soft-start capacitor and switch shorts
`timescale 1ns/1ps
module converter_far_side #(
    parameter CHG = 12 // Ramp length of gate and soft-start, cycles
) (
    input  wire core_clk,            // Clock
    input  wire breaker_gate_drive,  // Breaker source on
    input  wire soft_start_pulldown, // Discharge on
    input  wire short_inject,        // Shorted switch fitted
    output wire breaker_gate_good,   // Gate charged
    output wire soft_start_low,      // Soft-start discharged
    output wire short_detected       // Check sees the short
);
    int gate_q = 0;
    int ss_q = CHG;
    // Gate only charges while sourced and collapses the moment it stops
    always @(posedge core_clk) begin
        gate_q <= breaker_gate_drive ? gate_q + (gate_q < CHG) : 0;
        ss_q <= soft_start_pulldown ? ss_q - (ss_q > 0) : ss_q + (ss_q < CHG);
    end
    assign breaker_gate_good = gate_q >= CHG;
    assign soft_start_low = ss_q < 2;
    assign short_detected = short_inject;
endmodule // converter_far_side

/* verification/converter_protection_sequencer_bench.sv */
// Self-checking bench for the converter protection sequencer
`timescale 1ns/1ps
module converter_protection_sequencer_bench;
    logic core_clk = 1'b0, rst = 1'b1, bias_good = 1'b0, bias_low = 1'b0;
    logic master_enable_sense = 1'b0, master_enable_low = 1'b0, sync_resistor_present = 1'b0;
    logic high_port_overvolt_sense = 1'b0, low_port_overvolt_sense = 1'b0, boost_mode = 1'b0;
    logic ch1_enable = 1'b0, ch2_enable = 1'b0, ch1_zero_cross = 1'b0, ch2_zero_cross = 1'b0;
    logic ext_clock_in_valid = 1'b0, ext_clock_in_in_range = 1'b0, ext_clock_in_changed = 1'b0;
    logic pull_low = 1'b0, short_inject = 1'b0;
    wire  breaker_gate_good, soft_start_low, short_detected, fault_line_low_oe;
    wire  breaker_gate_drive, detect_active, standby, ch1_switch_en, ch2_switch_en;
    wire  ch1_rect_en, ch2_rect_en, soft_start_pulldown, ext_sync_locked, pll_settling;
    wire  [2:0] seq_state;
    // Open-drain fault line: low if either party pulls
    wire  fault_line_low_in = fault_line_low_oe | pull_low;
    int   bad_count = 0;
    int   checked = 0;
    converter_protection_sequencer #(.STANDBY_DELAY_CYC(20), .DETECT_TIME_CYC(40),
        .PLL_SETTLE_CYC(20)) i_dut (.*);
    converter_far_side #(.CHG(30)) i_far (.*);
    always #4 core_clk = ~core_clk;
    task automatic chk(input logic got, input logic exp);
        checked++;
        if (got !== exp) begin
            bad_count++;
            $display("BAD %0t flag %b expected %b", $time, got, exp);
        end
    endtask
    task automatic chk_st(input logic [2:0] exp);
        checked++;
        if (seq_state !== exp) begin
            bad_count++;
            $display("BAD %0t state %h expected %h", $time, seq_state, exp);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(negedge core_clk);
    endtask
    task automatic hold(input int n);
        repeat (n) @(posedge core_clk);
    endtask
    task automatic wait_st(input logic [2:0] s, input int lim);
        while (seq_state !== s && lim > 0) begin
            cyc(1);
            lim--;
        end
        chk_st(s);
    endtask
    task automatic power_up(input logic res);
        @(posedge core_clk) sync_resistor_present <= res;
        bias_good <= 1'b1;
        master_enable_sense <= 1'b1;
    endtask
    task automatic results;
        $display("checked %0d bad_count %0d", checked, bad_count);
        if (bad_count == 0 && checked > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    task automatic t_nodetect;
        power_up(1'b1);
        wait_st(3'h6, 8);
        chk(breaker_gate_drive, 1'b1);
        chk(detect_active, 1'b0);
        cyc(15);
        chk_st(3'h6);
        wait_st(3'h3, 10);
        chk(standby, 1'b1);
        chk(breaker_gate_good, 1'b0);
        $display("start-up without check done");
    endtask
    task automatic t_clock;
        @(posedge core_clk) ext_clock_in_valid <= 1'b1;
        ext_clock_in_in_range <= 1'b1;
        cyc(6);
        chk(ext_sync_locked, 1'b1);
        @(posedge core_clk) ext_clock_in_in_range <= 1'b0;
        cyc(6);
        chk(ext_sync_locked, 1'b0);
        // Channels stay disabled across the change
        @(posedge core_clk) ext_clock_in_changed <= 1'b1;
        cyc(6);
        chk(pll_settling, 1'b1);
        @(posedge core_clk) ext_clock_in_changed <= 1'b0;
        cyc(30);
        chk(pll_settling, 1'b0);
        $display("clock tracking done");
    endtask
    task automatic t_run;
        @(posedge core_clk) ch1_enable <= 1'b1;
        ch2_enable <= 1'b1;
        wait_st(3'h4, 4);
        cyc(40);
        chk(ch1_switch_en, 1'b1);
        chk(soft_start_pulldown, 1'b0);
        chk(ch1_rect_en, 1'b1);
        @(posedge core_clk) ch1_zero_cross <= 1'b1;
        cyc(5);
        chk(ch1_rect_en, 1'b0);
        chk(ch2_rect_en, 1'b1);
        @(posedge core_clk) ch1_zero_cross <= 1'b0;
        ch2_zero_cross <= 1'b1;
        cyc(5);
        chk(ch1_rect_en, 1'b1);
        chk(ch2_rect_en, 1'b0);
        @(posedge core_clk) ch2_zero_cross <= 1'b0;
        boost_mode <= 1'b1;
        low_port_overvolt_sense <= 1'b1;
        hold(700);
        low_port_overvolt_sense <= 1'b0;
        cyc(4);
        chk(ch1_switch_en, 1'b1);
        @(posedge core_clk) high_port_overvolt_sense <= 1'b1;
        hold(600);
        high_port_overvolt_sense <= 1'b0;
        cyc(4);
        chk(ch2_switch_en, 1'b1);
        @(posedge core_clk) high_port_overvolt_sense <= 1'b1;
        hold(640);
        cyc(1);
        chk(ch1_switch_en, 1'b0);
        chk(soft_start_pulldown, 1'b1);
        @(posedge core_clk) high_port_overvolt_sense <= 1'b0;
        cyc(700);
        chk(ch1_switch_en, 1'b1);
        chk(soft_start_pulldown, 1'b0);
        @(posedge core_clk) boost_mode <= 1'b0;
        low_port_overvolt_sense <= 1'b1;
        hold(640);
        cyc(1);
        chk(ch2_switch_en, 1'b0);
        @(posedge core_clk) low_port_overvolt_sense <= 1'b0;
        cyc(700);
        $display("run and overvoltage done");
    endtask
    task automatic t_fault;
        @(posedge core_clk) pull_low <= 1'b1;
        hold(200);
        pull_low <= 1'b0;
        cyc(8);
        chk_st(3'h4);
        @(posedge core_clk) pull_low <= 1'b1;
        hold(300);
        pull_low <= 1'b0;
        wait_st(3'h5, 8);
        chk(breaker_gate_drive, 1'b0);
        chk(fault_line_low_oe, 1'b0);
        cyc(10);
        chk_st(3'h5);
        @(posedge core_clk) master_enable_sense <= 1'b0;
        master_enable_low <= 1'b1;
        wait_st(3'h0, 8);
        @(posedge core_clk) master_enable_low <= 1'b0;
        ch1_enable <= 1'b0;
        ch2_enable <= 1'b0;
        // Fault filter must forget the old low before the next start-up
        cyc(260);
        $display("external fault done");
    endtask
    task automatic t_detect;
        power_up(1'b0);
        wait_st(3'h1, 8);
        chk(detect_active, 1'b1);
        cyc(30);
        chk_st(3'h1);
        wait_st(3'h2, 16);
        chk(breaker_gate_drive, 1'b1);
        wait_st(3'h3, 40);
        @(posedge core_clk) short_inject <= 1'b1;
        bias_good <= 1'b0;
        bias_low <= 1'b1;
        wait_st(3'h0, 8);
        @(posedge core_clk) bias_low <= 1'b0;
        bias_good <= 1'b1;
        wait_st(3'h1, 8);
        wait_st(3'h5, 48);
        chk(fault_line_low_oe, 1'b1);
        chk(breaker_gate_drive, 1'b0);
        @(posedge core_clk) bias_low <= 1'b1;
        bias_good <= 1'b0;
        wait_st(3'h0, 8);
        chk(fault_line_low_oe, 1'b0);
        $display("short check done");
    endtask
    initial begin
        hold(4);
        rst <= 1'b0;
        cyc(1);
        chk_st(3'h0);
        chk(soft_start_pulldown, 1'b1);
        chk(breaker_gate_drive, 1'b0);
        $display("reset done");
        t_nodetect;
        t_clock;
        t_run;
        t_fault;
        t_detect;
        results;
    end
    initial begin
        hold(20000);
        bad_count++;
        $display("BAD %0t watchdog expired", $time);
        results;
    end
endmodule // converter_protection_sequencer_bench
bind converter_protection_sequencer converter_protection_sequencer_properties i_props (.*);
